/* dsl_device.sv */
// dsl_device.sv: converter end of the serial load link
// assumes: pclk far faster than sclk, link pins asynchronous to pclk
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "dsl_cfg.svh"
module dsl_device (
  // link
  dsl_link_if.dev link,
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // converter controls
  output dsl_pkg::dsl_half_t dac_code,
  output logic [`SEG_N-1:0] seg_on,
  output logic [`LADDER_HI:0] ladder_bits,
  output logic volt_out_en,
  output logic cur_out_en,
  output logic chain_mode
);
  import dsl_pkg::*;

  // ****************************************
  // pin sampling and edge finding
  // ****************************************
  logic sclk_s;
  logic serial_data_in_s;
  logic latch_s;
  logic sclk_d_reg;
  logic latch_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic latch_rise;

  dsl_sync #(
    .W(3)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({link.sclk, link.serial_data_in, link.latch}),
    .q({sclk_s, serial_data_in_s, latch_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_reg <= 1'b0;
      latch_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      latch_d_reg <= latch_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign latch_rise = latch_s & ~latch_d_reg;

  // ****************************************
  // captured word decode
  // ****************************************
  dsl_word_t shift_reg;
  dsl_word_t shift_next;
  dsl_half_t data_reg;
  dsl_half_t ctrl_reg;
  dsl_half_t status_val;
  dsl_half_t rb_val;
  dsl_word_t rb_word;
  logic [`ADDR_HI-`ADDR_LO:0] cmd;
  dsl_half_t word_data;
  dsl_sel_t rd_sel;
  logic do_data;
  logic do_read;
  logic do_ctrl;
  logic do_rst;

  assign cmd = shift_reg[`ADDR_HI:`ADDR_LO];
  assign word_data = shift_reg[`DATA_HI:0];
  assign rd_sel = shift_reg[`SEL_HI:0];

  always_comb begin
    do_data = 1'b0;
    do_read = 1'b0;
    do_ctrl = 1'b0;
    do_rst = 1'b0;
    if (latch_rise) begin
      if (cmd == `CMD_DATA) begin
        do_data = 1'b1;
      end else if (cmd == `CMD_READ) begin
        do_read = 1'b1;
      end else if (cmd == `CMD_CTRL) begin
        do_ctrl = 1'b1;
      end else if (cmd == `CMD_RST) begin
        do_rst = 1'b1;
      end else begin
        // nop and unknown codes leave data_reg and ctrl_reg alone; any latch but a read still clears rb_active_reg
        do_data = 1'b0;
      end
    end
  end

  // ****************************************
  // readback source
  // ****************************************
  always_comb begin
    status_val = `RST_VAL_DATA;
    status_val[`DEV_STAT_VOLT] = volt_out_en;
    status_val[`DEV_STAT_CUR] = cur_out_en;
  end

  always_comb begin
    case (rd_sel)
      `RD_STATUS: rb_val = status_val;
      `RD_DATA: rb_val = data_reg;
      `RD_CTRL: rb_val = ctrl_reg;
      default: rb_val = `RST_VAL_DATA;
    endcase
    rb_word = {`CMD_NOP, rb_val};
  end

  // ****************************************
  // input shift register
  // ****************************************
  always_comb begin
    shift_next = shift_reg;
    if (do_read) begin
      shift_next = rb_word;
    end else if (sclk_rise) begin
      shift_next = {shift_reg[`WORD_MSB-1:0], serial_data_in_s};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= `RST_VAL_WORD;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // ****************************************
  // data and control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= `RST_VAL_DATA;
    end else if (do_rst && word_data[`RST_BIT]) begin
      data_reg <= `RST_VAL_DATA;
    end else if (do_data) begin
      data_reg <= word_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RST_VAL_DATA;
    end else if (do_rst && word_data[`RST_BIT]) begin
      ctrl_reg <= `RST_VAL_DATA;
    end else if (do_ctrl) begin
      ctrl_reg <= word_data;
    end
  end

  // ****************************************
  // serial output and its enable
  // ****************************************
  logic sdo_reg;
  logic rb_active_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_active_reg <= 1'b0;
    end else if (latch_rise) begin
      rb_active_reg <= do_read;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_reg <= 1'b0;
    end else if (do_read) begin
      sdo_reg <= rb_word[`WORD_MSB];
    end else if (sclk_fall) begin
      sdo_reg <= shift_reg[`WORD_MSB];
    end
  end

  assign link.serial_data_out = sdo_reg;
  assign link.sdo_oe = rb_active_reg | ctrl_reg[`CTRL_CHAIN];

  // ****************************************
  // converter controls
  // ****************************************
  logic [`MSB_GRP_W-1:0] msb_grp;
  logic [`CTRL_RNG_HI:0] range;
  assign msb_grp = data_reg[`DATA_HI:`DATA_W-`MSB_GRP_W];
  assign range = ctrl_reg[`CTRL_RNG_HI:`CTRL_RNG_LO];

  genvar gi;
  generate
    for (gi = 0; gi < `SEG_N; gi = gi + 1) begin : g_seg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seg_on[gi] <= 1'b0;
        end else begin
          seg_on[gi] <= (msb_grp > `MSB_GRP_W'(gi));
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_out_en <= 1'b0;
      cur_out_en <= 1'b0;
    end else begin
      volt_out_en <= ctrl_reg[`CTRL_OUTEN] & ~range[`CTRL_RNG_HI];
      cur_out_en <= ctrl_reg[`CTRL_OUTEN] & range[`CTRL_RNG_HI] &
        (range[`CTRL_RNG_HI-1:0] != '0);
    end
  end

  assign dac_code = data_reg;
  assign ladder_bits = data_reg[`LADDER_HI:0];
  assign chain_mode = ctrl_reg[`CTRL_CHAIN];

endmodule // dsl_device

/* dsl_cfg.svh */
// dsl_cfg.svh: constants of the serial load link, both ends
// assumes: included by bare name wherever a constant is needed
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH
// ****************************************
// word layout
// ****************************************
`define WORD_W 24
`define WORD_MSB 23
`define ADDR_HI 23
`define ADDR_LO 16
`define DATA_W 16
`define DATA_HI 15
`define SEL_HI 1
// ****************************************
// address byte codes
// ****************************************
`define CMD_NOP 8'h00
`define CMD_DATA 8'h01
`define CMD_READ 8'h02
`define CMD_CTRL 8'h55
`define CMD_RST 8'h56
// ****************************************
// readback select codes
// ****************************************
`define RD_STATUS 2'h0
`define RD_DATA 2'h1
`define RD_CTRL 2'h2
// ****************************************
// control and reset fields, device status
// ****************************************
`define CTRL_CHAIN 3
`define CTRL_OUTEN 12
`define CTRL_RNG_HI 2
`define CTRL_RNG_LO 0
`define RST_BIT 0
`define DEV_STAT_VOLT 0
`define DEV_STAT_CUR 1
`define RST_VAL_DATA 16'h0000
`define RST_VAL_WORD 24'h000000
// ****************************************
// segment decoder
// ****************************************
`define SEG_N 15
`define MSB_GRP_W 4
`define LADDER_W 12
`define LADDER_HI 11
// ****************************************
// host registers on apb
// ****************************************
`define HOST_TX 12'h000
`define HOST_CMD 12'h004
`define HOST_STAT 12'h008
`define HOST_RX 12'h00C
`define CMD_GO 0
`define CMD_HOLD 1
`define STAT_BUSY 0
`define STAT_DONE 1
`define RST_VAL_APB 32'h00000000
// ****************************************
// timing
// ****************************************
`define PCLK_MHZ 125
`define SCLK_MAX_MHZ 30
`define SCLK_HALF_MIN ((`PCLK_MHZ + 2 * `SCLK_MAX_MHZ - 1) / (2 * `SCLK_MAX_MHZ))
`define SCLK_HALF_DEF 4
`define HALF_CNT_W 8
`define BIT_CNT_W 5
`endif

/* dsl_pkg.sv */
// dsl_pkg.sv: types shared by both ends of the serial load link
// assumes: dsl_cfg.svh is on the include path
package dsl_pkg;
`include "dsl_cfg.svh"
  typedef logic [`WORD_MSB:0] dsl_word_t;
  typedef logic [`DATA_HI:0] dsl_half_t;
  typedef logic [`SEL_HI:0] dsl_sel_t;
  typedef enum logic [2:0] {
    DSL_IDLE = 3'b000,
    DSL_LOW = 3'b001,
    DSL_HIGH = 3'b010,
    DSL_LSET = 3'b011,
    DSL_LHI = 3'b100
  } dsl_host_state_t;
endpackage

/* dsl_link_if.sv */
// dsl_link_if.sv: the link wires between host and device
// assumes: a pull-up on the serial output line when nobody drives it
`timescale 1ns/10ps
interface dsl_link_if;
  logic sclk;
  logic serial_data_in;
  logic latch;
  logic serial_data_out;
  logic sdo_oe;
  logic sdo_line;
  // resolved level of the serial output wire
  assign sdo_line = sdo_oe ? serial_data_out : 1'b1;
  modport host (
    output sclk,
    output serial_data_in,
    output latch,
    input sdo_line
  );
  modport dev (
    input sclk,
    input serial_data_in,
    input latch,
    output serial_data_out,
    output sdo_oe
  );
endinterface

/* dsl_sync.sv */
// dsl_sync.sv: two flip-flop synchroniser, one lane per bit
// assumes: inputs are asynchronous levels
`timescale 1ns/10ps
module dsl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // lanes
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // dsl_sync

/* dsl_host.sv */
// dsl_host.sv: controller end, apb slave that runs the serial link
// assumes: software writes a word, then a go bit, then polls busy
`timescale 1ns/10ps
`include "dsl_cfg.svh"
module dsl_host #(
  parameter int HALF = `SCLK_HALF_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  dsl_link_if.host link
);
  import dsl_pkg::*;

  // ****************************************
  // apb decode
  // ****************************************
  dsl_word_t tx_reg;
  dsl_word_t rx_reg;
  logic done_reg;
  logic hit;
  logic [31:0] rd_val;
  logic access;
  logic go;
  logic busy;
  dsl_host_state_t state_reg;

  assign access = psel & penable;
  assign busy = (state_reg != DSL_IDLE);

  always_comb begin
    hit = 1'b1;
    rd_val = `RST_VAL_APB;
    if (paddr == `HOST_TX) begin
      rd_val[`WORD_MSB:0] = tx_reg;
    end else if (paddr == `HOST_CMD) begin
      rd_val = `RST_VAL_APB;
    end else if (paddr == `HOST_STAT) begin
      rd_val[`STAT_BUSY] = busy;
      rd_val[`STAT_DONE] = done_reg;
    end else if (paddr == `HOST_RX) begin
      rd_val[`WORD_MSB:0] = rx_reg;
    end else begin
      hit = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign go = access & pwrite & (paddr == `HOST_CMD) &
    pwdata[`CMD_GO] & ~busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_VAL_APB;
    end else if (psel && !penable) begin
      prdata <= rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= `RST_VAL_WORD;
    end else if (access && pwrite && paddr == `HOST_TX) begin
      tx_reg <= pwdata[`WORD_MSB:0];
    end
  end

  // ****************************************
  // link sequencer
  // ****************************************
  logic sdo_s;
  logic [`HALF_CNT_W-1:0] cnt_reg;
  logic [`BIT_CNT_W-1:0] bit_reg;
  dsl_word_t out_reg;
  logic hold_reg;
  logic sclk_reg;
  logic latch_reg;
  logic tick;
  localparam logic [`HALF_CNT_W-1:0] HALF_LD = `HALF_CNT_W'(HALF - 1);
  localparam logic [`BIT_CNT_W-1:0] LAST_BIT = `BIT_CNT_W'(`WORD_W - 1);

  dsl_sync #(
    .W(1)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.sdo_line),
    .q(sdo_s)
  );

  assign tick = (cnt_reg == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DSL_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      out_reg <= `RST_VAL_WORD;
      rx_reg <= `RST_VAL_WORD;
      hold_reg <= 1'b0;
      sclk_reg <= 1'b0;
      latch_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= tick ? HALF_LD : cnt_reg - 1'b1;
      case (state_reg)
        DSL_IDLE: begin
          if (go) begin
            state_reg <= DSL_LOW;
            cnt_reg <= HALF_LD;
            bit_reg <= LAST_BIT;
            out_reg <= tx_reg;
            hold_reg <= pwdata[`CMD_HOLD];
            done_reg <= 1'b0;
          end
        end
        DSL_LOW: begin
          if (tick) begin
            state_reg <= DSL_HIGH;
            sclk_reg <= 1'b1;
          end
        end
        DSL_HIGH: begin
          if (tick) begin
            sclk_reg <= 1'b0;
            rx_reg <= {rx_reg[`WORD_MSB-1:0], sdo_s};
            out_reg <= {out_reg[`WORD_MSB-1:0], 1'b0};
            bit_reg <= bit_reg - 1'b1;
            if (bit_reg != '0) begin
              state_reg <= DSL_LOW;
            end else if (hold_reg) begin
              state_reg <= DSL_IDLE;
              done_reg <= 1'b1;
            end else begin
              state_reg <= DSL_LSET;
            end
          end
        end
        DSL_LSET: begin
          if (tick) begin
            state_reg <= DSL_LHI;
            latch_reg <= 1'b1;
          end
        end
        DSL_LHI: begin
          if (tick) begin
            state_reg <= DSL_IDLE;
            latch_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= DSL_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.serial_data_in = out_reg[`WORD_MSB];
  assign link.latch = latch_reg;

endmodule // dsl_host

/* dsl_checker.sv */
// dsl_checker.sv: checks on the link wires between host and device
// assumes: host built with HALF of 4, one pclk for both ends
`timescale 1ns/10ps
module dsl_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic latch,
  input wire logic serial_data_out,
  input wire logic sdo_oe
);
  logic sclk_q;
  logic latch_q;
  logic [6:0] rise_cnt;
  logic [3:0] since_lat;
  // ****************************************
  // helper logic
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      latch_q <= latch;
    end
  end
  // sclk rises since the last latch rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rise_cnt <= 7'h00;
    else if (latch && !latch_q) rise_cnt <= 7'h00;
    else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 7'h01;
  end
  // cycles since the last latch rise, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_lat <= 4'hF;
    else if (latch && !latch_q) since_lat <= 4'h0;
    else if (since_lat != 4'hF) since_lat <= since_lat + 4'h1;
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sclk_half_a: assert property (
    $rose(sclk) |=> sclk[*3] ##1 !sclk) else $error("sclk high time wrong");
  serial_data_in_hold_a: assert property (
    $rose(sclk) |=> ($stable(serial_data_in))[*3]) else $error("serial_data_in moved in high");
  latch_quiet_a: assert property (
    latch |-> !sclk) else $error("sclk high during latch");
  latch_width_a: assert property (
    $rose(latch) |=> latch[*3] ##1 !latch) else $error("latch width wrong");
  bit_count_a: assert property (
    $rose(latch) |-> rise_cnt != 7'h00 && rise_cnt % 24 == 0)
    else $error("latch after wrong bit count");
  sdo_fall_a: assert property (
    $changed(serial_data_out) |-> !sclk) else $error("sdo moved in high");
  sdo_enable_a: assert property (
    $changed(sdo_oe) |-> since_lat < 4'hA) else $error("sdo enable not latch");
  sdo_first_a: assert property (
    $rose(sdo_oe) |-> !serial_data_out) else $error("sdo first bit not 0");
endmodule // dsl_checker

/* testbench.sv */
// testbench.sv: host and device joined, driven over apb
// assumes: dsl_cfg.svh on the include path, default HALF of 4
`timescale 1ns/10ps
`include "dsl_cfg.svh"
module testbench;
  import dsl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, want, obs_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  dsl_half_t dac_code, d, m_dac, m_ctrl;
  logic [14:0] seg_on;
  logic [11:0] ladder_bits;
  logic volt_out_en, cur_out_en, chain_mode;
  logic [47:0] exp_q[$], e;
  logic [7:0] bad [4] = '{8'h00, 8'h03, 8'hAA, 8'hFF};
  logic [15:0] ctl [4] = '{16'h1000, 16'h1005, 16'h0005, 16'h1004};
  int err_total, checks_done;
  dsl_link_if dsl_link_if_i ();
  dsl_host dsl_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(dsl_link_if_i.host));
  dsl_device dsl_device_i (.link(dsl_link_if_i.dev), .pclk(pclk),
    .presetn(presetn), .dac_code(dac_code), .seg_on(seg_on),
    .ladder_bits(ladder_bits), .volt_out_en(volt_out_en),
    .cur_out_en(cur_out_en), .chain_mode(chain_mode));
  dsl_checker dsl_checker_i (.pclk(pclk), .presetn(presetn),
    .sclk(dsl_link_if_i.sclk), .serial_data_in(dsl_link_if_i.serial_data_in),
    .latch(dsl_link_if_i.latch),
    .serial_data_out(dsl_link_if_i.serial_data_out),
    .sdo_oe(dsl_link_if_i.sdo_oe));
  always #4 pclk = ~pclk;
  // ****************************************
  // checking
  // ****************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    err_total += exp_q.size();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && want) begin
      check({15'h0, pslverr, prdata}, exp_q.pop_front());
    end
    if (obs_go) begin
      check({2'h0, ladder_bits, chain_mode, cur_out_en, volt_out_en,
        seg_on, dac_code}, exp_q.pop_front());
    end
  end
  function automatic logic [47:0] exp_state();
    logic [14:0] t;
    for (int i = 0; i < 15; i++) t[i] = (m_dac[15:12] > i);
    return {2'h0, m_dac[11:0], m_ctrl[3],
      m_ctrl[12] & m_ctrl[2] & (m_ctrl[1:0] != 2'h0),
      m_ctrl[12] & ~m_ctrl[2], t, m_dac};
  endfunction
  // ****************************************
  // driving
  // ****************************************
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] dat, input logic chk);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= dat;
    want <= chk;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      give_verdict();
    end
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    want <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] ex);
    exp_q.push_back({15'h0, ex});
    apb(a, 1'b0, 32'h0, 1'b1);
  endtask
  task automatic send(input logic [23:0] w, input logic hold);
    int n;
    apb(`HOST_TX, 1'b1, {8'h00, w}, 1'b0);
    apb(`HOST_CMD, 1'b1, {30'h0, hold, 1'b1}, 1'b0);
    n = 0;
    do begin
      apb(`HOST_STAT, 1'b0, 32'h0, 1'b0);
      n++;
    end while (rd_val[1:0] !== 2'b10 && n < 300);
    if (n >= 300) begin
      err_total++;
      give_verdict();
    end
    repeat (8) @(posedge pclk);
  endtask
  task automatic probe();
    exp_q.push_back(exp_state());
    obs_go <= 1'b1;
    @(posedge pclk);
    obs_go <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rb(input logic [1:0] s, input logic [15:0] v);
    send({`CMD_READ, 14'h0, s}, 1'b0);
    send(24'h000000, 1'b0);
    rd(`HOST_RX, {17'h0, v});
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, want, obs_go} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {err_total, checks_done} = 0;
    m_dac = 16'h0000;
    m_ctrl = 16'h0000;
    void'($urandom(28752));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    probe();
    rd(`HOST_STAT, 33'h0);
    send(24'h000000, 1'b0);
    rd(`HOST_RX, 33'h00FFFFFF);
    rd(`HOST_STAT, 33'h2);
    rd(12'h010, {1'b1, 32'h0});
    rd(`HOST_CMD, 33'h0);
    rb(`RD_CTRL, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom());
      send({`CMD_DATA, d}, 1'b0);
      m_dac = d;
      probe();
      rb(`RD_DATA, d);
    end
    foreach (bad[i]) begin
      send({bad[i], 16'h1234}, 1'b0);
      probe();
    end
    foreach (ctl[i]) begin
      m_ctrl = ctl[i];
      send({`CMD_CTRL, ctl[i]}, 1'b0);
      probe();
      rb(`RD_CTRL, ctl[i]);
      e = exp_state();
      rb(`RD_STATUS, {14'h0, e[32], e[31]});
    end
    rb(2'h3, 16'h0000);
    send({`CMD_RST, 16'h0001}, 1'b0);
    m_dac = 16'h0000;
    m_ctrl = 16'h0000;
    probe();
    send({`CMD_DATA, 16'hA5C3}, 1'b1);
    probe();
    send({`CMD_DATA, 16'h5A3C}, 1'b0);
    m_dac = 16'h5A3C;
    probe();
    m_ctrl = 16'h0008;
    send({`CMD_CTRL, 16'h0008}, 1'b0);
    probe();
    send(24'h01BEEF, 1'b1);
    send({`CMD_CTRL, 16'h0000}, 1'b0);
    rd(`HOST_RX, 33'h0001BEEF);
    rd(`HOST_TX, 33'h00550000);
    m_ctrl = 16'h0000;
    probe();
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule // testbench
